// ### hw/srhc_pkg.sv
// Constants, timing counts and state type of the static memory host.
// Function
// - Read: strobe high, output enable low, selected
// - Write: strobe low, both selects, a lane
// - Write ends at first control going inactive
// - Host never fights memory-driven data pins
// - Lane enables gate bytes zero and one
package srhc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LANE_W = 8;
  localparam int unsigned LANES = 2;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned CNT_W = 4;

  // ----------------------------------------------------------------
  // Timing in nanoseconds and derived cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_RC_NS = 70;
  localparam int unsigned T_AA_NS = 70;
  localparam int unsigned T_WC_NS = 70;
  localparam int unsigned T_WP_NS = 50;
  localparam int unsigned T_DW_NS = 30;
  localparam int unsigned T_WHZ_NS = 20;
  localparam int unsigned T_WR_NS = 0;

  function automatic int unsigned srhc_cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int unsigned srhc_max(input int unsigned a,
                                           input int unsigned b);
    return (a > b) ? a : b;
  endfunction

  localparam int unsigned RC_CYC = srhc_cyc_up(T_RC_NS);
  localparam int unsigned AA_CYC = srhc_cyc_up(T_AA_NS);
  localparam int unsigned WC_CYC = srhc_cyc_up(T_WC_NS);
  localparam int unsigned WP_CYC = srhc_cyc_up(T_WP_NS);
  localparam int unsigned DW_CYC = srhc_cyc_up(T_DW_NS);
  localparam int unsigned WHZ_CYC = srhc_cyc_up(T_WHZ_NS);
  localparam int unsigned WR_CYC = srhc_cyc_up(T_WR_NS);
  localparam int unsigned RD_WAIT =
    srhc_max(AA_CYC + SYNC_STAGES, RC_CYC - 1);
  localparam int unsigned REC_CYC =
    srhc_max(WR_CYC, (WC_CYC > WP_CYC + 1) ? WC_CYC - WP_CYC - 1 : 0);

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded along each cycle except the ST_RD_DONE to ST_IDLE step
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD = 3'h1,
    ST_RD_DONE = 3'h3,
    ST_WR_SET = 3'h2,
    ST_WR_PULSE = 3'h6,
    ST_WR_REC = 3'h4
  } srhc_state_t;

endpackage

// ### hw/srhc_tmr_if.sv
// Interface between the sequencer and its cycle timer.
`timescale 1ns/1ps
interface srhc_tmr_if #(
  parameter int unsigned CNT_W = 4
);
  logic load;
  logic [CNT_W-1:0] load_val;
  logic [CNT_W-1:0] remain;
  logic done;

  modport owner (output load, output load_val, input remain, input done);
  modport timer (input load, input load_val, output remain, output done);
endinterface

// ### hw/srhc_timer.sv
// Down counter that times each phase of a memory access.
`timescale 1ns/1ps
module srhc_timer #(
  parameter int unsigned CNT_W = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Sequencer side
  srhc_tmr_if.timer tmr
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (tmr.load) begin
      next_count = tmr.load_val;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign tmr.remain = count;
  assign tmr.done = (count == '0);

endmodule

// ### hw/srhc_ctrl.sv
// Host sequencer that reads and writes an asynchronous static memory.
`timescale 1ns/1ps
module srhc_ctrl
  import srhc_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned DW = DATA_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // User request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [LANES-1:0] req_lanes,
  input wire logic [DW-1:0] req_wdata,
  output logic req_ready,
  // User answer
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  // Memory pins
  output logic [AW-1:0] sram_addr,
  output logic select_low_active,
  output logic select_high_active,
  output logic write_strobe_n,
  output logic output_enable_n,
  output logic low_lane_enable_n,
  output logic high_lane_enable_n,
  output logic [DW-1:0] data_bus_o,
  output logic data_bus_oe,
  input wire logic [DW-1:0] data_bus_i
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The pulse must leave room for bus turnaround plus data overlap.
  if (AW != ADDR_W || DW != LANES * LANE_W) begin : g_bad_geom
    $error("srhc_ctrl: unsupported address or data width");
  end
  if (WP_CYC < WHZ_CYC + DW_CYC) begin : g_bad_pulse
    $error("srhc_ctrl: write pulse too short for data overlap");
  end
  if (RD_WAIT >= (1 << CNT_W) || REC_CYC >= (1 << CNT_W)) begin : g_bad_cnt
    $error("srhc_ctrl: timer too narrow");
  end

  localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_WAIT);
  localparam logic [CNT_W-1:0] WP_LOAD = CNT_W'(WP_CYC - 1);
  localparam logic [CNT_W-1:0] REC_LOAD = CNT_W'(REC_CYC - 1);
  localparam logic [CNT_W-1:0] DRIVE_AT = CNT_W'(WP_CYC - WHZ_CYC);

  // Expand lane enables into a per-bit mask.
  function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] l);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++) begin
      m[i*LANE_W +: LANE_W] = {LANE_W{l[i]}};
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Timer
  // ----------------------------------------------------------------
  srhc_tmr_if #(.CNT_W(CNT_W)) tmr ();

  srhc_timer #(.CNT_W(CNT_W)) u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tmr(tmr)
  );

  // ----------------------------------------------------------------
  // Read data synchroniser
  // ----------------------------------------------------------------
  logic [DW-1:0] rd_meta;
  logic [DW-1:0] rd_sync;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_meta <= '0;
      rd_sync <= '0;
    end else begin
      rd_meta <= data_bus_i;
      rd_sync <= rd_meta;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  srhc_state_t state;
  srhc_state_t next_state;
  logic [LANES-1:0] lanes;
  logic [LANES-1:0] next_lanes;
  logic next_req_ready;
  logic next_rsp_valid;
  logic [DW-1:0] next_rsp_rdata;
  logic [AW-1:0] next_sram_addr;
  logic next_selected;
  logic next_write_strobe_n;
  logic next_output_enable_n;
  logic [DW-1:0] next_data_bus_o;
  logic next_data_bus_oe;

  always_comb begin
    next_state = state;
    next_lanes = lanes;
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    next_sram_addr = sram_addr;
    next_selected = ~select_low_active;
    next_write_strobe_n = 1'b1;
    next_output_enable_n = 1'b1;
    next_data_bus_o = data_bus_o;
    next_data_bus_oe = data_bus_oe;
    tmr.load = 1'b0;
    tmr.load_val = '0;
    case (state)
      ST_IDLE: begin
        next_req_ready = 1'b1;
        next_selected = 1'b0;
        next_data_bus_oe = 1'b0;
        next_lanes = '0;
        if (req_valid && req_ready) begin
          next_req_ready = 1'b0;
          if (req_lanes == '0) begin
            // No lane: nothing can reach the memory, reads answer zero.
            next_rsp_valid = ~req_write;
            next_rsp_rdata = '0;
            next_req_ready = 1'b1;
          end else if (req_write) begin
            // Select first with strobe high: memory output stays off.
            next_state = ST_WR_SET;
            next_sram_addr = req_addr;
            next_lanes = req_lanes;
            next_selected = 1'b1;
            next_data_bus_o = req_wdata;
          end else begin
            next_state = ST_RD;
            next_sram_addr = req_addr;
            next_lanes = req_lanes;
            next_selected = 1'b1;
            next_output_enable_n = 1'b0;
            tmr.load = 1'b1;
            tmr.load_val = RD_LOAD;
          end
        end
      end
      ST_RD: begin
        next_output_enable_n = 1'b0;
        if (tmr.done) begin
          next_state = ST_RD_DONE;
          next_selected = 1'b0;
          next_output_enable_n = 1'b1;
          next_rsp_valid = 1'b1;
          next_rsp_rdata = rd_sync & lane_mask(lanes);
          next_lanes = '0;
        end
      end
      ST_RD_DONE: begin
        next_state = ST_IDLE;
        next_selected = 1'b0;
        next_req_ready = 1'b1;
      end
      ST_WR_SET: begin
        next_state = ST_WR_PULSE;
        next_write_strobe_n = 1'b0;
        tmr.load = 1'b1;
        tmr.load_val = WP_LOAD;
      end
      ST_WR_PULSE: begin
        next_write_strobe_n = 1'b0;
        // Drive only after the memory has surely floated the bus.
        if (tmr.remain <= DRIVE_AT) begin
          next_data_bus_oe = 1'b1;
        end
        if (tmr.done) begin
          // Strobe rises first; select and data hold through recovery.
          next_state = ST_WR_REC;
          next_write_strobe_n = 1'b1;
          tmr.load = 1'b1;
          tmr.load_val = REC_LOAD;
        end
      end
      ST_WR_REC: begin
        if (tmr.done) begin
          next_state = ST_IDLE;
          next_selected = 1'b0;
          next_data_bus_oe = 1'b0;
          next_lanes = '0;
          next_req_ready = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_selected = 1'b0;
        next_data_bus_oe = 1'b0;
        next_lanes = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      lanes <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      sram_addr <= '0;
      select_low_active <= 1'b1;
      select_high_active <= 1'b0;
      write_strobe_n <= 1'b1;
      output_enable_n <= 1'b1;
      low_lane_enable_n <= 1'b1;
      high_lane_enable_n <= 1'b1;
      data_bus_o <= '0;
      data_bus_oe <= 1'b0;
    end else begin
      state <= next_state;
      lanes <= next_lanes;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      sram_addr <= next_sram_addr;
      select_low_active <= ~next_selected;
      select_high_active <= next_selected;
      write_strobe_n <= next_write_strobe_n;
      output_enable_n <= next_output_enable_n;
      low_lane_enable_n <= ~next_lanes[0];
      high_lane_enable_n <= ~next_lanes[1];
      data_bus_o <= next_data_bus_o;
      data_bus_oe <= next_data_bus_oe;
    end
  end

endmodule

// ### verif/srhc_props.sv
// Checker of the memory pin protocol driven by the host.
`timescale 1ns/1ps
module srhc_props
  import srhc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [LANES-1:0] req_lanes,
  input wire logic req_ready,
  input wire logic rsp_valid,
  // Memory pins
  input wire logic select_low_active,
  input wire logic select_high_active,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic low_lane_enable_n,
  input wire logic high_lane_enable_n,
  input wire logic data_bus_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic sel;
  logic lane;
  logic take;
  assign sel = !select_low_active && select_high_active;
  assign lane = !(low_lane_enable_n && high_lane_enable_n);
  assign take = req_valid && req_ready && (req_lanes != 2'h0);

  chk_sel_pair: assert property (
    select_high_active != select_low_active)
    else $error("select pins disagree");
  chk_no_fight: assert property (
    data_bus_oe |-> output_enable_n)
    else $error("host drives while memory output enabled");
  chk_write_mode: assert property (
    !write_strobe_n |-> sel && lane)
    else $error("strobe low without selection");
  chk_read_mode: assert property (
    !output_enable_n |-> sel && lane && write_strobe_n)
    else $error("output enable outside a read");
  chk_pulse_width: assert property (
    $fell(write_strobe_n) |-> !write_strobe_n [*3] ##1 write_strobe_n)
    else $error("write pulse has wrong width");
  chk_write_end: assert property (
    $rose(write_strobe_n) |-> sel ##1 !sel)
    else $error("selection not held past strobe rise");
  chk_read_answer: assert property (
    take && !req_write |=> !output_enable_n [*7] ##1 rsp_valid)
    else $error("read access or answer mistimed");
  chk_write_ready: assert property (
    take && req_write |=> !req_ready [*5] ##1 req_ready)
    else $error("write recovery mistimed");
  chk_no_lane: assert property (
    req_valid && req_ready && req_lanes == 2'h0 && !req_write
      |=> rsp_valid && !sel)
    else $error("empty lane read reached memory");
  chk_data_overlap: assert property (
    !write_strobe_n && $past(write_strobe_n) == 1'b0 |-> data_bus_oe)
    else $error("write data not driven during strobe");
endmodule

bind srhc_ctrl srhc_props i_srhc_props (.clk_sys, .resetn, .req_valid,
  .req_write, .req_lanes, .req_ready, .rsp_valid, .select_low_active,
  .select_high_active, .write_strobe_n, .output_enable_n,
  .low_lane_enable_n, .high_lane_enable_n, .data_bus_oe);

// ### verif/srhc_sram_model.sv
// Behavioural model of the asynchronous static memory on its pins.
`timescale 1ns/1ps
module srhc_sram_model
  import srhc_pkg::*;
(
  // Pattern clock for released lines
  input wire logic clk_sys,
  // Memory pins
  input wire logic [ADDR_W-1:0] sram_addr,
  input wire logic select_low_active,
  input wire logic select_high_active,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic low_lane_enable_n,
  input wire logic high_lane_enable_n,
  input wire logic [DATA_W-1:0] data_bus_o,
  input wire logic data_bus_oe,
  output logic [DATA_W-1:0] data_bus_i
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] flt = 16'hA5C3;
  logic [DATA_W-1:0] lm;
  logic sel;
  logic wr;
  logic rd;
  // Released lines change every cycle so stale data never looks valid.
  always @(posedge clk_sys) flt <= ~flt;
  assign lm = {{LANE_W{!high_lane_enable_n}}, {LANE_W{!low_lane_enable_n}}};
  assign sel = !select_low_active && select_high_active &&
    lm != 16'h0000;
  assign wr = sel && !write_strobe_n;
  assign rd = sel && write_strobe_n && !output_enable_n;
  // Lines the host leaves floating during a write store garbage.
  always @(wr, sram_addr, lm, data_bus_o, data_bus_oe, flt) begin
    if (wr) begin
      mem[sram_addr] = (mem[sram_addr] & ~lm) |
        ((data_bus_oe ? data_bus_o : flt) & lm);
    end
  end
  assign data_bus_i = rd ?
    ((mem[sram_addr] & lm) | (flt & ~lm)) :
    data_bus_oe ? data_bus_o : flt;
endmodule

// ### verif/testbench.sv
// Self-checking bench of the static memory host with a memory model.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("wrong value %s expected %h seen %h", nm, e, g); \
  end end
module testbench
  import srhc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = 19'h00000;
  logic [LANES-1:0] req_lanes = 2'h0;
  logic [DATA_W-1:0] req_wdata = 16'h0000;
  logic req_ready, rsp_valid, select_low_active, select_high_active;
  logic write_strobe_n, output_enable_n, low_lane_enable_n;
  logic high_lane_enable_n, data_bus_oe;
  logic [DATA_W-1:0] rsp_rdata, data_bus_o, data_bus_i;
  logic [ADDR_W-1:0] sram_addr;
  int n_mismatch = 0;
  int cmp_count = 0;

  srhc_ctrl i_srhc_ctrl (.clk_sys, .resetn, .req_valid, .req_write,
    .req_addr, .req_lanes, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
    .sram_addr, .select_low_active, .select_high_active, .write_strobe_n,
    .output_enable_n, .low_lane_enable_n, .high_lane_enable_n, .data_bus_o,
    .data_bus_oe, .data_bus_i);
  srhc_sram_model i_srhc_sram_model (.clk_sys, .sram_addr,
    .select_low_active, .select_high_active, .write_strobe_n,
    .output_enable_n, .low_lane_enable_n, .high_lane_enable_n, .data_bus_o,
    .data_bus_oe, .data_bus_i);

  always #10 clk_sys = ~clk_sys;

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic hang();
    n_mismatch++;
    summarize();
  endtask

  task automatic chk_idle();
    logic [6:0] pins;
    pins = {select_low_active, select_high_active, write_strobe_n,
      output_enable_n, low_lane_enable_n, high_lane_enable_n, data_bus_oe};
    `CHK("idle pins", 7'h5E, pins)
  endtask

  task automatic send(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [LANES-1:0] ln, input logic [DATA_W-1:0] d);
    int k;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_lanes = ln;
    req_wdata = d;
    k = 0;
    // Ready is judged settled, so the next edge is the taking edge.
    while (req_ready !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k >= 20) hang();
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln,
                    input logic [DATA_W-1:0] d);
    int n;
    send(1'b1, a, ln, d);
    n = 0;
    repeat (7) begin
      @(posedge clk_sys);
      #1;
      if (write_strobe_n === 1'b0) n++;
    end
    `CHK("pulse cycles", (ln != 2'h0) ? WP_CYC : 0, n)
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln,
                    input logic [DATA_W-1:0] e);
    int k;
    send(1'b0, a, ln, 16'h0000);
    k = 0;
    while (rsp_valid !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k >= 20) hang();
    `CHK("read data", e, rsp_rdata)
  endtask

  task automatic t_word();
    wr(19'h00000, 2'h3, 16'h1234);
    rd(19'h00000, 2'h3, 16'h1234);
  endtask

  task automatic t_lanes();
    wr(19'h00005, 2'h3, 16'hA55A);
    wr(19'h00005, 2'h1, 16'h99C3);
    rd(19'h00005, 2'h3, 16'hA5C3);
    wr(19'h00005, 2'h2, 16'h7E11);
    rd(19'h00005, 2'h2, 16'h7E00);
    rd(19'h00005, 2'h1, 16'h00C3);
  endtask

  task automatic t_edge();
    wr(19'h7FFFF, 2'h3, 16'hFFFF);
    wr(19'h7FFFE, 2'h3, 16'h0001);
    rd(19'h7FFFF, 2'h3, 16'hFFFF);
    rd(19'h7FFFE, 2'h3, 16'h0001);
  endtask

  task automatic t_nolane();
    rd(19'h00005, 2'h0, 16'h0000);
    wr(19'h00005, 2'h0, 16'h1111);
    rd(19'h00005, 2'h3, 16'h7EC3);
  endtask

  task automatic t_abort();
    send(1'b1, 19'h00009, 2'h3, 16'h5555);
    repeat (2) @(posedge clk_sys);
    #1;
    resetn = 1'b0;
    #1;
    chk_idle();
    repeat (2) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    rd(19'h00005, 2'h3, 16'h7EC3);
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    chk_idle();
    t_word();
    t_lanes();
    t_edge();
    t_nolane();
    t_abort();
    summarize();
  end
endmodule
